// ---- rtl/had_decoder.sv ----
// Host address decoder: routes upper-range and system-management memory requests.
//
// Function
// - Processor accesses to FEC0_0000h..FEC7_FFFFh always go to the south link.
// - SMM-mode processor accesses to the enabled high segment go to DRAM A_0000h..B_FFFFh.
// - Non-SMM processor accesses to the enabled high segment are invalid, ended at once.
// - Writebacks and full-line WB writes to the high segment complete to DRAM anyway.
// - Port and south link requests never reach any enabled SMM space.
// - DRAM at the high segment's own addresses is never remapped or reachable.
// - Downstream writes to FEExxxxxh become processor-bus interrupt messages with data.
// - The decoder ends those interrupt messages itself with response and target ready.
// - The top 2 MB goes to the south link, aliasing below 16 MB.
// - A 256-MB configuration window decodes at a programmable aligned base.
// - Non-prefetchable port window hits when base <= address <= limit.
// - Prefetchable port window hits when base < address < limit.
// - Both port windows are off unless the port memory-enable bit is set.
// - Graphics control, aperture and table windows go to integrated graphics.
// - Compatible and top-of-memory SMM spaces are used without remapping.
// - Top-of-memory SMM segment is 1, 2 or 8 MB just below stolen memory.
// - With global and high enables set, compatible SMM space is disabled.
`default_nettype none
module had_decoder
	import had_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	input wire logic req_valid_i,
	input wire logic [31:0] req_addr_i,
	input wire had_pkg::had_source_e req_src_i,
	input wire logic req_write_i,
	input wire logic req_smm_i,
	input wire logic req_wb_i,
	input wire logic [31:0] req_data_i,
	output logic rsp_valid_o,
	output had_pkg::had_target_e rsp_target_o,
	output logic [31:0] rsp_addr_o,
	output logic [31:0] rsp_data_o,
	output logic rsp_intr_msg_o,
	output logic rsp_resp_phase_o,
	output logic target_ready_n_o
);
	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [31:0] top_of_low_dram_reg, top_of_low_dram_next;
	logic [31:0] stolen_reg, stolen_next;
	logic [31:0] cfgbase_reg, cfgbase_next;
	logic [31:0] port_mem_base_reg, port_mem_base_next;
	logic [31:0] port_mem_limit_reg, port_mem_limit_next;
	logic [31:0] pbase_reg, pbase_next;
	logic [31:0] plimit_reg, plimit_next;
	logic [31:0] gctrl_reg, gctrl_next;
	logic [31:0] gaper_reg, gaper_next;
	logic [31:0] gtable_reg, gtable_next;
	logic [31:0] winmask_reg, winmask_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] invalid_cnt_reg, invalid_cnt_next;
	logic ev_invalid;

	always_comb begin
		ctrl_next = ctrl_reg;
		top_of_low_dram_next = top_of_low_dram_reg;
		stolen_next = stolen_reg;
		cfgbase_next = cfgbase_reg;
		port_mem_base_next = port_mem_base_reg;
		port_mem_limit_next = port_mem_limit_reg;
		pbase_next = pbase_reg;
		plimit_next = plimit_reg;
		gctrl_next = gctrl_reg;
		gaper_next = gaper_reg;
		gtable_next = gtable_reg;
		winmask_next = winmask_reg;
		rdata_next = ZERO_ADDR;
		// Refused cycles are counted for software; the count wraps at its width.
		invalid_cnt_next = invalid_cnt_reg + {7'h00, ev_invalid};
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				REG_CTRL: ctrl_next = reg_wdata_i[CTRL_W-1:0];
				REG_TOP_OF_LOW_DRAM: top_of_low_dram_next = reg_wdata_i;
				REG_STOLEN: stolen_next = reg_wdata_i;
				REG_CFGBASE: cfgbase_next = reg_wdata_i & CFG_WIN_MASK;
				REG_PORT_MEM_BASE: port_mem_base_next = reg_wdata_i;
				REG_PORT_MEM_LIMIT: port_mem_limit_next = reg_wdata_i;
				REG_PBASE: pbase_next = reg_wdata_i;
				REG_PLIMIT: plimit_next = reg_wdata_i;
				REG_GCTRL: gctrl_next = reg_wdata_i;
				REG_GAPER: gaper_next = reg_wdata_i;
				REG_GTABLE: gtable_next = reg_wdata_i;
				REG_WINMASK: winmask_next = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL: rdata_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
				REG_TOP_OF_LOW_DRAM: rdata_next = top_of_low_dram_reg;
				REG_STOLEN: rdata_next = stolen_reg;
				REG_CFGBASE: rdata_next = cfgbase_reg;
				REG_PORT_MEM_BASE: rdata_next = port_mem_base_reg;
				REG_PORT_MEM_LIMIT: rdata_next = port_mem_limit_reg;
				REG_PBASE: rdata_next = pbase_reg;
				REG_PLIMIT: rdata_next = plimit_reg;
				REG_GCTRL: rdata_next = gctrl_reg;
				REG_GAPER: rdata_next = gaper_reg;
				REG_GTABLE: rdata_next = gtable_reg;
				REG_WINMASK: rdata_next = winmask_reg;
				REG_STATUS: rdata_next = {24'h00_0000, invalid_cnt_reg};
				default: rdata_next = ZERO_ADDR;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg <= '0;
			top_of_low_dram_reg <= ZERO_ADDR;
			stolen_reg <= ZERO_ADDR;
			cfgbase_reg <= ZERO_ADDR;
			port_mem_base_reg <= ZERO_ADDR;
			port_mem_limit_reg <= ZERO_ADDR;
			pbase_reg <= ZERO_ADDR;
			plimit_reg <= ZERO_ADDR;
			gctrl_reg <= ZERO_ADDR;
			gaper_reg <= ZERO_ADDR;
			gtable_reg <= ZERO_ADDR;
			winmask_reg <= ZERO_ADDR;
			rdata_reg <= ZERO_ADDR;
			invalid_cnt_reg <= 8'h00;
		end else begin
			ctrl_reg <= ctrl_next;
			top_of_low_dram_reg <= top_of_low_dram_next;
			stolen_reg <= stolen_next;
			cfgbase_reg <= cfgbase_next;
			port_mem_base_reg <= port_mem_base_next;
			port_mem_limit_reg <= port_mem_limit_next;
			pbase_reg <= pbase_next;
			plimit_reg <= plimit_next;
			gctrl_reg <= gctrl_next;
			gaper_reg <= gaper_next;
			gtable_reg <= gtable_next;
			winmask_reg <= winmask_next;
			rdata_reg <= rdata_next;
			invalid_cnt_reg <= invalid_cnt_next;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ------------------------------------------------------------
	// Fixed regions
	// ------------------------------------------------------------
	// Inclusive compare used for the APIC, interrupt and compatible SMM regions.
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// Legacy video cycles follow the routing bit to the port, otherwise the south link.
	function automatic had_target_e legacy_target(input logic vga);
		legacy_target = vga ? HAD_TGT_PORT : HAD_TGT_SOUTH;
	endfunction

	logic apic_hit, intr_hit, compat_raw, bios_hit;

	// These regions are fixed in the map, so no register can move or hide them.
	always_comb begin
		apic_hit = in_range(req_addr_i, APIC_LO, APIC_HI);
		intr_hit = in_range(req_addr_i, INTR_LO, INTR_HI);
		compat_raw = in_range(req_addr_i, CSMM_LO, CSMM_HI);
		bios_hit = req_addr_i >= BIOS_LO;
	end

	// ------------------------------------------------------------
	// Window decode
	// ------------------------------------------------------------
	// Graphics windows share one size mask so all three stay naturally aligned.
	function automatic logic win_hit(input logic [31:0] a, input logic [31:0] base,
		input logic [31:0] mask);
		win_hit = ((a & ~mask) == (base & ~mask)) && (base != ZERO_ADDR);
	endfunction

	logic port_mem_hit, port_pref_hit;
	logic csmm_hit, high_smm_segment_hit, top_memory_smm_segment_hit, high_smm_segment_raw;

	// The port memory-enable bit gates both windows, overriding any base and limit.
	had_window #(.EXCLUSIVE(1'b0)) u_port_mem (
		.addr_i(req_addr_i),
		.base_i(port_mem_base_reg),
		.limit_i(port_mem_limit_reg),
		.enable_i(ctrl_reg[C_PMEM]),
		.hit_o(port_mem_hit)
	);

	had_window #(.EXCLUSIVE(1'b1)) u_port_pref (
		.addr_i(req_addr_i),
		.base_i(pbase_reg),
		.limit_i(plimit_reg),
		.enable_i(ctrl_reg[C_PMEM]),
		.hit_o(port_pref_hit)
	);

	had_smm_check u_smm (
		.addr_i(req_addr_i),
		.ctrl_i(ctrl_reg),
		.top_of_low_dram_i(top_of_low_dram_reg),
		.stolen_i(stolen_reg),
		.csmm_hit_o(csmm_hit),
		.high_smm_segment_hit_o(high_smm_segment_hit),
		.top_memory_smm_segment_hit_o(top_memory_smm_segment_hit),
		.high_smm_segment_raw_o(high_smm_segment_raw)
	);

	// ------------------------------------------------------------
	// Routing
	// ------------------------------------------------------------
	logic rsp_valid_reg, rsp_valid_next;
	had_target_e rsp_target_reg, rsp_target_next;
	logic [31:0] rsp_addr_reg, rsp_addr_next;
	logic [31:0] rsp_data_reg, rsp_data_next;
	logic intr_reg, intr_next;
	logic resp_reg, resp_next;
	logic trdy_n_reg, trdy_n_next;

	// Branch order is the priority: downstream refusals first, then fixed regions, then windows; the compatible override below wins over all.
	always_comb begin
		logic from_cpu;
		logic gfx_hit;
		logic cfg_hit;
		logic smm_data_ok;
		from_cpu = 1'b0;
		gfx_hit = 1'b0;
		cfg_hit = 1'b0;
		smm_data_ok = 1'b0;
		from_cpu = (req_src_i == HAD_SRC_CPU);
		gfx_hit = ctrl_reg[C_GFX] && (win_hit(req_addr_i, gctrl_reg, winmask_reg)
			|| win_hit(req_addr_i, gaper_reg, winmask_reg)
			|| win_hit(req_addr_i, gtable_reg, winmask_reg));
		cfg_hit = ctrl_reg[C_CFG]
			&& ((req_addr_i & CFG_WIN_MASK) == cfgbase_reg);
		smm_data_ok = req_smm_i || ctrl_reg[C_OPEN];
		rsp_valid_next = req_valid_i;
		rsp_target_next = HAD_TGT_SOUTH;
		rsp_addr_next = req_addr_i;
		rsp_data_next = req_data_i;
		intr_next = 1'b0;
		resp_next = 1'b0;
		trdy_n_next = 1'b1;
		if (!req_valid_i) begin
			rsp_valid_next = 1'b0;
		end else if (!from_cpu && (high_smm_segment_hit || csmm_hit || top_memory_smm_segment_hit)) begin
			// Downstream masters see invalid cycles to address zero.
			rsp_target_next = HAD_TGT_INVALID;
			rsp_addr_next = ZERO_ADDR;
		end else if (!from_cpu && req_write_i && intr_hit) begin
			rsp_target_next = HAD_TGT_PBUS;
			intr_next = 1'b1;
			resp_next = 1'b1;
			trdy_n_next = 1'b0;
		end else if (from_cpu && apic_hit) begin
			rsp_target_next = HAD_TGT_SOUTH;
		end else if (from_cpu && high_smm_segment_hit) begin
			if (req_smm_i || req_wb_i) begin
				// Writebacks must land in DRAM to keep the cached copy coherent.
				rsp_target_next = HAD_TGT_DRAM;
				rsp_addr_next = req_addr_i - HIGH_SMM_SEGMENT_TO_CSMM;
			end else begin
				rsp_target_next = HAD_TGT_INVALID;
				rsp_addr_next = ZERO_ADDR;
			end
		end else if (from_cpu && (csmm_hit || top_memory_smm_segment_hit)) begin
			if (smm_data_ok || req_wb_i) begin
				rsp_target_next = HAD_TGT_DRAM;
			end else begin
				rsp_target_next = legacy_target(csmm_hit && ctrl_reg[C_VGA]);
				if (top_memory_smm_segment_hit) begin
					rsp_target_next = HAD_TGT_INVALID;
					rsp_addr_next = ZERO_ADDR;
				end
			end
		end else if (high_smm_segment_raw) begin
			// The segment's own DRAM stays hidden; unremapped hits fall to the south link.
			rsp_target_next = HAD_TGT_SOUTH;
		end else if (bios_hit) begin
			rsp_target_next = HAD_TGT_SOUTH;
			rsp_addr_next = req_addr_i & BIOS_ALIAS_MASK;
		end else if (cfg_hit) begin
			rsp_target_next = HAD_TGT_CFG;
		end else if (gfx_hit) begin
			rsp_target_next = HAD_TGT_GFX;
		end else if (port_mem_hit || port_pref_hit) begin
			rsp_target_next = HAD_TGT_PORT;
		end else if (req_addr_i < top_of_low_dram_reg) begin
			rsp_target_next = HAD_TGT_DRAM;
		end
		// A compatible hit with the high segment on is legacy video space, port or south link.
		if (req_valid_i && from_cpu && ctrl_reg[C_GSMM] && ctrl_reg[C_HSMM] && compat_raw) begin
			rsp_target_next = legacy_target(ctrl_reg[C_VGA]);
		end
	end

	assign ev_invalid = rsp_valid_next && (rsp_target_next == HAD_TGT_INVALID);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rsp_valid_reg <= 1'b0;
			rsp_target_reg <= HAD_TGT_SOUTH;
			rsp_addr_reg <= ZERO_ADDR;
			rsp_data_reg <= ZERO_ADDR;
			intr_reg <= 1'b0;
			resp_reg <= 1'b0;
			trdy_n_reg <= 1'b1;
		end else begin
			rsp_valid_reg <= rsp_valid_next;
			rsp_target_reg <= rsp_target_next;
			rsp_addr_reg <= rsp_addr_next;
			rsp_data_reg <= rsp_data_next;
			intr_reg <= intr_next;
			resp_reg <= resp_next;
			trdy_n_reg <= trdy_n_next;
		end
	end

	assign rsp_valid_o = rsp_valid_reg;
	assign rsp_target_o = rsp_target_reg;
	assign rsp_addr_o = rsp_addr_reg;
	assign rsp_data_o = rsp_data_reg;
	assign rsp_intr_msg_o = intr_reg;
	assign rsp_resp_phase_o = resp_reg;
	assign target_ready_n_o = trdy_n_reg;
endmodule
`default_nettype wire

// ---- rtl/had_pkg.sv ----
// Package of address map constants and enumerations for the host address decoder.
`default_nettype none
package had_pkg;
	localparam int ADDR_W = 32;
	localparam logic [31:0] APIC_LO = 32'hFEC0_0000;
	localparam logic [31:0] APIC_HI = 32'hFEC7_FFFF;
	localparam logic [31:0] HIGH_SMM_SEGMENT_LO = 32'hFEDA_0000;
	localparam logic [31:0] HIGH_SMM_SEGMENT_HI = 32'hFEDB_FFFF;
	localparam logic [31:0] CSMM_LO = 32'h000A_0000;
	localparam logic [31:0] CSMM_HI = 32'h000B_FFFF;
	localparam logic [31:0] INTR_LO = 32'hFEE0_0000;
	localparam logic [31:0] INTR_HI = 32'hFEEF_FFFF;
	localparam logic [31:0] BIOS_LO = 32'hFFE0_0000;
	localparam logic [31:0] BIOS_ALIAS_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] HIGH_SMM_SEGMENT_TO_CSMM = 32'hFED0_0000;
	localparam logic [31:0] CFG_WIN_MASK = 32'hF000_0000;
	localparam logic [31:0] TOP_MEMORY_SMM_SEGMENT_1M = 32'h0010_0000;
	localparam logic [31:0] TOP_MEMORY_SMM_SEGMENT_2M = 32'h0020_0000;
	localparam logic [31:0] TOP_MEMORY_SMM_SEGMENT_8M = 32'h0080_0000;
	localparam logic [31:0] ZERO_ADDR = 32'h0000_0000;
	localparam logic [1:0] TOP_MEMORY_SMM_SEGMENT_SZ_1M = 2'h0;
	localparam logic [1:0] TOP_MEMORY_SMM_SEGMENT_SZ_2M = 2'h1;
	localparam logic [1:0] TOP_MEMORY_SMM_SEGMENT_SZ_8M = 2'h2;
	// Register map of the control port.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TOP_OF_LOW_DRAM = 4'h1;
	localparam logic [3:0] REG_STOLEN = 4'h2;
	localparam logic [3:0] REG_CFGBASE = 4'h3;
	localparam logic [3:0] REG_PORT_MEM_BASE = 4'h4;
	localparam logic [3:0] REG_PORT_MEM_LIMIT = 4'h5;
	localparam logic [3:0] REG_PBASE = 4'h6;
	localparam logic [3:0] REG_PLIMIT = 4'h7;
	localparam logic [3:0] REG_GCTRL = 4'h8;
	localparam logic [3:0] REG_GAPER = 4'h9;
	localparam logic [3:0] REG_GTABLE = 4'hA;
	localparam logic [3:0] REG_WINMASK = 4'hB;
	localparam logic [3:0] REG_STATUS = 4'hC;
	// Control register bit positions.
	localparam int C_GSMM = 0;
	localparam int C_HSMM = 1;
	localparam int C_TOP_MEMORY_SMM_SEGMENT = 2;
	localparam int C_TSZ = 3;
	localparam int C_PMEM = 5;
	localparam int C_CFG = 6;
	localparam int C_GFX = 7;
	localparam int C_VGA = 8;
	localparam int C_OPEN = 9;
	localparam int C_CLS = 10;
	localparam int CTRL_W = 11;
	typedef enum logic [2:0] {
		HAD_TGT_SOUTH,
		HAD_TGT_PORT,
		HAD_TGT_GFX,
		HAD_TGT_PBUS,
		HAD_TGT_DRAM,
		HAD_TGT_INVALID,
		HAD_TGT_CFG
	} had_target_e;
	typedef enum logic [1:0] {
		HAD_SRC_CPU,
		HAD_SRC_PORT,
		HAD_SRC_SOUTH
	} had_source_e;
endpackage
`default_nettype wire

// ---- rtl/had_smm_check.sv ----
// System-management space classifier: which enabled segment an address hits.
`default_nettype none
module had_smm_check
	import had_pkg::*;
(
	input wire logic [31:0] addr_i,
	input wire logic [CTRL_W-1:0] ctrl_i,
	input wire logic [31:0] top_of_low_dram_i,
	input wire logic [31:0] stolen_i,
	output logic csmm_hit_o,
	output logic high_smm_segment_hit_o,
	output logic top_memory_smm_segment_hit_o,
	output logic high_smm_segment_raw_o
);
	logic [31:0] top_memory_smm_segment_size;
	logic [31:0] top_memory_smm_segment_top;
	logic [31:0] top_memory_smm_segment_bot;
	always_comb begin
		unique case (ctrl_i[C_TSZ +: 2])
			TOP_MEMORY_SMM_SEGMENT_SZ_2M: top_memory_smm_segment_size = TOP_MEMORY_SMM_SEGMENT_2M;
			TOP_MEMORY_SMM_SEGMENT_SZ_8M: top_memory_smm_segment_size = TOP_MEMORY_SMM_SEGMENT_8M;
			default: top_memory_smm_segment_size = TOP_MEMORY_SMM_SEGMENT_1M;
		endcase
		top_memory_smm_segment_top = top_of_low_dram_i - stolen_i;
		top_memory_smm_segment_bot = top_memory_smm_segment_top - top_memory_smm_segment_size;
		high_smm_segment_raw_o = (addr_i >= HIGH_SMM_SEGMENT_LO) && (addr_i <= HIGH_SMM_SEGMENT_HI);
		high_smm_segment_hit_o = ctrl_i[C_GSMM] && ctrl_i[C_HSMM] && high_smm_segment_raw_o;
		csmm_hit_o = ctrl_i[C_GSMM] && !ctrl_i[C_HSMM]
			&& (addr_i >= CSMM_LO) && (addr_i <= CSMM_HI);
		top_memory_smm_segment_hit_o = ctrl_i[C_GSMM] && ctrl_i[C_TOP_MEMORY_SMM_SEGMENT]
			&& (addr_i >= top_memory_smm_segment_bot) && (addr_i < top_memory_smm_segment_top);
	end
endmodule
`default_nettype wire

// ---- rtl/had_window.sv ----
// Base and limit comparator for one address window, inclusive or exclusive.
`default_nettype none
module had_window
	import had_pkg::*;
#(
	parameter bit EXCLUSIVE = 1'b0
) (
	input wire logic [31:0] addr_i,
	input wire logic [31:0] base_i,
	input wire logic [31:0] limit_i,
	input wire logic enable_i,
	output logic hit_o
);
	always_comb begin
		if (EXCLUSIVE) begin
			hit_o = enable_i && (addr_i > base_i) && (addr_i < limit_i);
		end else begin
			hit_o = enable_i && (addr_i >= base_i) && (addr_i <= limit_i);
		end
	end
endmodule
`default_nettype wire

// ---- test/had_decoder_chk.sv ----
// Port-level assertions for the host address decoder.
`default_nettype none
module had_decoder_chk
	import had_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic req_valid_i,
	input wire logic [31:0] req_addr_i,
	input wire had_pkg::had_source_e req_src_i,
	input wire logic req_write_i,
	input wire logic req_smm_i,
	input wire logic req_wb_i,
	input wire logic [31:0] req_data_i,
	input wire logic rsp_valid_o,
	input wire had_pkg::had_target_e rsp_target_o,
	input wire logic [31:0] rsp_addr_o,
	input wire logic [31:0] rsp_data_o,
	input wire logic rsp_intr_msg_o,
	input wire logic rsp_resp_phase_o,
	input wire logic target_ready_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [CTRL_W-1:0] ctrl_reg;
	logic [CTRL_W-1:0] ctrl_next;
	logic hi_on, cpu, in_hi;
	// --------------------------------------------------------------
	// Shadow of the control register
	// --------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		if (reg_wr_i && reg_addr_i == REG_CTRL) begin
			ctrl_next = reg_wdata_i[CTRL_W-1:0];
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end
	assign hi_on = ctrl_reg[C_GSMM] & ctrl_reg[C_HSMM];
	assign cpu = req_valid_i && req_src_i == HAD_SRC_CPU;
	assign in_hi = req_addr_i >= HIGH_SMM_SEGMENT_LO && req_addr_i <= HIGH_SMM_SEGMENT_HI;
	property p_apic;
		cpu && req_addr_i >= APIC_LO && req_addr_i <= APIC_HI |=> rsp_target_o == HAD_TGT_SOUTH;
	endproperty
	a_apic: assert property (p_apic) else $error("apic range not routed south");
	property p_hi_map;
		cpu && in_hi && hi_on && (req_smm_i || req_wb_i) |=> rsp_target_o == HAD_TGT_DRAM
			&& rsp_addr_o == $past(req_addr_i) - HIGH_SMM_SEGMENT_TO_CSMM;
	endproperty
	a_hi_map: assert property (p_hi_map) else $error("high segment remap wrong");
	property p_hi_bad;
		cpu && in_hi && hi_on && !req_smm_i && !req_wb_i |=> rsp_target_o == HAD_TGT_INVALID;
	endproperty
	a_hi_bad: assert property (p_hi_bad) else $error("high segment not refused");
	property p_hi_off;
		cpu && in_hi && !hi_on |=> rsp_target_o != HAD_TGT_DRAM;
	endproperty
	a_hi_off: assert property (p_hi_off) else $error("dram behind high segment reached");
	property p_dn_smm;
		req_valid_i && req_src_i != HAD_SRC_CPU && in_hi && hi_on |=> rsp_target_o == HAD_TGT_INVALID;
	endproperty
	a_dn_smm: assert property (p_dn_smm) else $error("downstream reached smm space");
	property p_intr;
		req_valid_i && req_src_i != HAD_SRC_CPU && req_write_i && req_addr_i >= INTR_LO
			&& req_addr_i <= INTR_HI |=> rsp_intr_msg_o && rsp_target_o == HAD_TGT_PBUS
			&& rsp_data_o == $past(req_data_i);
	endproperty
	a_intr: assert property (p_intr) else $error("interrupt write not forwarded");
	property p_end;
		rsp_intr_msg_o |-> rsp_resp_phase_o && !target_ready_n_o && rsp_valid_o;
	endproperty
	a_end: assert property (p_end) else $error("interrupt message not ended");
	property p_bios;
		req_valid_i && req_addr_i >= BIOS_LO |=> rsp_target_o == HAD_TGT_SOUTH
			&& rsp_addr_o == ($past(req_addr_i) & BIOS_ALIAS_MASK);
	endproperty
	a_bios: assert property (p_bios) else $error("boot area alias wrong");
endmodule
bind had_decoder had_decoder_chk had_decoder_chk_inst (.clk_i, .arst_n_i, .reg_addr_i,
	.reg_wdata_i, .reg_wr_i, .req_valid_i, .req_addr_i, .req_src_i, .req_write_i, .req_smm_i,
	.req_wb_i, .req_data_i, .rsp_valid_o, .rsp_target_o, .rsp_addr_o, .rsp_data_o,
	.rsp_intr_msg_o, .rsp_resp_phase_o, .target_ready_n_o);
`default_nettype wire

// ---- test/had_far_model.sv ----
// Far-side requester model for the processor bus and the downstream links.
`default_nettype none
module had_far_model
	import had_pkg::*;
(
	input wire logic clk_i,
	output logic req_valid_o,
	output had_pkg::had_source_e req_src_o,
	output logic [31:0] req_addr_o,
	output logic req_write_o,
	output logic req_smm_o,
	output logic req_wb_o,
	output logic [31:0] req_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_valid_o = 1'b0;
		req_src_o = HAD_SRC_CPU;
		req_addr_o = 32'h0000_0000;
		{req_write_o, req_smm_o, req_wb_o} = 3'h0;
		req_data_o = 32'h0000_0000;
	end
	// Requests carry untranslated physical addresses only.
	task automatic send(input had_source_e s, input logic [31:0] a, input logic [2:0] f);
		@(posedge clk_i);
		req_valid_o <= 1'b1;
		req_src_o <= s;
		req_addr_o <= a;
		{req_write_o, req_smm_o, req_wb_o} <= f;
		req_data_o <= ~a;
	endtask
	// Idle lines turn over so that a stale address never passes for a live one.
	task automatic quiet();
		@(posedge clk_i);
		req_valid_o <= 1'b0;
		req_addr_o <= ~req_addr_o;
		req_data_o <= ~req_data_o;
	endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking testbench for the host address decoder.
`default_nettype none
module tb;
	import had_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0] s;
		logic [31:0] a;
		logic [2:0] f;
		logic [2:0] t;
		logic [31:0] e;
	} had_row_s;
	localparam int N = 22;
	// Source, address, {write, smm, writeback}, target, routed address.
	had_row_s rows [N] = '{
		'{2'h0,32'hFEC0_0000,3'h0,3'h0,32'hFEC0_0000},
		'{2'h0,32'hFEDA_0010,3'h2,3'h4,32'h000A_0010},
		'{2'h0,32'hFEDB_FFFC,3'h0,3'h5,32'h0},
		'{2'h0,32'hFEDA_0100,3'h5,3'h4,32'h000A_0100},
		'{2'h2,32'hFEDA_0000,3'h4,3'h5,32'h0},
		'{2'h1,32'h3F70_0000,3'h0,3'h5,32'h0},
		'{2'h0,32'h3F70_0004,3'h2,3'h4,32'h3F70_0004},
		'{2'h0,32'h000A_0000,3'h2,3'h0,32'h000A_0000},
		'{2'h2,32'hFEE0_1000,3'h4,3'h3,32'hFEE0_1000},
		'{2'h1,32'hFEEF_FFFC,3'h4,3'h3,32'hFEEF_FFFC},
		'{2'h0,32'hFFE0_0000,3'h0,3'h0,32'h00E0_0000},
		'{2'h0,32'hE000_0000,3'h0,3'h6,32'hE000_0000},
		'{2'h0,32'hF000_0000,3'h0,3'h0,32'hF000_0000},
		'{2'h0,32'hC000_0000,3'h0,3'h1,32'hC000_0000},
		'{2'h0,32'hC0FF_FFFF,3'h0,3'h1,32'hC0FF_FFFF},
		'{2'h0,32'hD000_0000,3'h0,3'h0,32'hD000_0000},
		'{2'h0,32'hD100_0000,3'h0,3'h0,32'hD100_0000},
		'{2'h0,32'hD0FF_FFFC,3'h0,3'h1,32'hD0FF_FFFC},
		'{2'h0,32'hD800_0100,3'h0,3'h2,32'hD800_0100},
		'{2'h0,32'hD900_0100,3'h0,3'h2,32'hD900_0100},
		'{2'h0,32'hDA00_0100,3'h0,3'h2,32'hDA00_0100},
		'{2'h0,32'h8000_0000,3'h0,3'h0,32'h8000_0000}
	};
	logic [31:0] sz [3] = '{TOP_MEMORY_SMM_SEGMENT_1M, TOP_MEMORY_SMM_SEGMENT_2M, TOP_MEMORY_SMM_SEGMENT_8M};
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, req_addr, req_data, rsp_addr, rsp_data;
	logic req_valid, req_write, req_smm, req_wb, rsp_valid, rsp_intr, rsp_resp, trdy_n;
	had_source_e req_src;
	had_target_e rsp_target;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	had_far_model had_far_model_inst (.clk_i(clk), .req_valid_o(req_valid), .req_src_o(req_src),
		.req_addr_o(req_addr), .req_write_o(req_write), .req_smm_o(req_smm), .req_wb_o(req_wb),
		.req_data_o(req_data));
	had_decoder had_decoder_inst (.clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.req_valid_i(req_valid), .req_addr_i(req_addr), .req_src_i(req_src),
		.req_write_i(req_write), .req_smm_i(req_smm), .req_wb_i(req_wb), .req_data_i(req_data),
		.rsp_valid_o(rsp_valid), .rsp_target_o(rsp_target), .rsp_addr_o(rsp_addr),
		.rsp_data_o(rsp_data), .rsp_intr_msg_o(rsp_intr), .rsp_resp_phase_o(rsp_resp),
		.target_ready_n_o(trdy_n));
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 cmp(reg_rdata, e);
	endtask
	task automatic chk(input had_row_s r);
		cmp(32'(rsp_valid), 32'h1);
		cmp(32'(rsp_target), 32'(r.t));
		cmp(rsp_addr, r.e);
		cmp(32'({rsp_intr, rsp_resp, trdy_n}), (r.t == 3'h3) ? 32'h6 : 32'h1);
		if (r.t == 3'h3) begin
			cmp(rsp_data, ~r.a);
		end
	endtask
	task automatic one(input had_row_s r);
		had_far_model_inst.send(had_source_e'(r.s), r.a, r.f);
		had_far_model_inst.quiet();
		#1 chk(r);
		// A lone request answers for one cycle only.
		@(posedge clk);
		#1 cmp(32'({rsp_valid, rsp_intr, rsp_resp, trdy_n}), 32'h1);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			conclude();
		end
	end
	// --------------------------------------------------------------
	// Stimulus
	// --------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		cmp(reg_rdata, 32'h0);
		cmp(32'(rsp_valid), 32'h0);
		cmp(32'(trdy_n), 32'h1);
		arst_n <= 1'b1;
		wr(REG_TOP_OF_LOW_DRAM, 32'h4000_0000);
		wr(REG_STOLEN, 32'h0080_0000);
		wr(REG_CFGBASE, 32'hE123_4567);
		rd(REG_CFGBASE, 32'hE000_0000);
		wr(REG_PORT_MEM_BASE, 32'hC000_0000);
		wr(REG_PORT_MEM_LIMIT, 32'hC0FF_FFFF);
		wr(REG_PBASE, 32'hD000_0000);
		wr(REG_PLIMIT, 32'hD100_0000);
		wr(REG_GCTRL, 32'hD800_0000);
		wr(REG_GAPER, 32'hD900_0000);
		wr(REG_GTABLE, 32'hDA00_0000);
		wr(REG_WINMASK, 32'h000F_FFFF);
		// Open and close stay clear; the top segment sits clear of every window.
		wr(REG_CTRL, 32'h0000_00E7);
		rd(REG_CTRL, 32'h0000_00E7);
		rd(4'hD, 32'h0000_0000);
		for (int i = 0; i <= N; i++) begin
			if (i < N) begin
				had_far_model_inst.send(had_source_e'(rows[i].s), rows[i].a, rows[i].f);
			end else begin
				had_far_model_inst.quiet();
			end
			#1;
			if (i > 0) begin
				chk(rows[i - 1]);
			end
		end
		for (int k = 0; k < 3; k++) begin
			wr(REG_CTRL, 32'h0000_00E7 | (32'(k) << C_TSZ));
			one('{2'h0, 32'h3F80_0000 - sz[k], 3'h0, 3'h5, 32'h0});
			one('{2'h0, 32'h3F7F_FFFC - sz[k], 3'h0, 3'h4, 32'h3F7F_FFFC - sz[k]});
		end
		wr(REG_CTRL, 32'h0000_01E7);
		one('{2'h0, 32'h000B_0000, 3'h2, 3'h1, 32'h000B_0000});
		wr(REG_CTRL, 32'h0000_00C7);
		one('{2'h0, 32'hC000_0000, 3'h0, 3'h0, 32'hC000_0000});
		one('{2'h0, 32'hD000_0004, 3'h0, 3'h0, 32'hD000_0004});
		wr(REG_CTRL, 32'h0000_0001);
		one('{2'h0, 32'hFEDA_0000, 3'h2, 3'h0, 32'hFEDA_0000});
		one('{2'h0, 32'h000A_0000, 3'h2, 3'h4, 32'h000A_0000});
		one('{2'h2, 32'h000A_0000, 3'h4, 3'h5, 32'h0});
		wr(REG_CTRL, 32'h0000_0101);
		one('{2'h0, 32'h000B_FFFC, 3'h0, 3'h1, 32'h000B_FFFC});
		wr(REG_CTRL, 32'h0000_0201);
		one('{2'h0, 32'h000A_0000, 3'h0, 3'h4, 32'h000A_0000});
		rd(REG_STATUS, 32'h0000_0007);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		cmp(32'({rsp_valid, trdy_n}), 32'h1);
		rd(REG_CTRL, 32'h0000_0000);
		rd(REG_STATUS, 32'h0000_0000);
		conclude();
	end
endmodule
`default_nettype wire
